// ### shared/otgm_defs.svh
`ifndef OTGM_DEFS_SVH
`define OTGM_DEFS_SVH

// ****************************************************************
// Register word indices
// ****************************************************************
// Printed offsets are register indices; each register takes one word.
`define OTGM_IDX_MISC_SET      6'h18
`define OTGM_IDX_MISC_CLR      6'h19
`define OTGM_IDX_CAR_SET       6'h1A
`define OTGM_IDX_CAR_CLR       6'h1B
`define OTGM_IDX_HI_WIDTH      6'h1C
`define OTGM_IDX_LO_WIDTH      6'h1D

// ****************************************************************
// Field positions
// ****************************************************************
`define OTGM_MISC_FORCE_HIGH   7
`define OTGM_MISC_FORCE_LOW    6
`define OTGM_MISC_LEVEL_SEL    4
`define OTGM_MISC_ID_PU_DIS    3
`define OTGM_MISC_WEAK_PU      2
`define OTGM_MISC_SRP_START    1
`define OTGM_MISC_BYPASS_DIS   0
`define OTGM_CAR_RIGHT_SW      5
`define OTGM_CAR_LEFT_SW       4
`define OTGM_CAR_RIGHT_BIAS    3
`define OTGM_CAR_LEFT_BIAS     2
`define OTGM_CAR_RX_PULSE      1
`define OTGM_CAR_TX_PULSE      0

// ****************************************************************
// Reset values and writable masks
// ****************************************************************
`define OTGM_MISC_RESET        8'h10
`define OTGM_CAR_RESET         8'h00
`define OTGM_HI_WIDTH_RESET    8'h15
`define OTGM_LO_WIDTH_RESET    8'h2A
`define OTGM_MISC_MASK         8'hDF
`define OTGM_CAR_MASK          8'h3F

// ****************************************************************
// Timing
// ****************************************************************
`define OTGM_CLK_KHZ           64'd125000
`define OTGM_PULSE_CLK_MHZ     8'h3C
`define OTGM_SYS_CLK_MHZ       8'h7D
`define OTGM_SRP_PULLUP_US     64'd7500
`define OTGM_SRP_CHARGE_US     64'd32000
`define OTGM_SRP_DISCHARGE_US  64'd13000

`endif

// ### shared/otgm_pkg.sv
package otgm_pkg;

   // Analog and line controls leaving the block, all registered.
   typedef struct packed {
      logic dp_drive;
      logic dp_drive_en;
      logic dp_pullup;
      logic dp_weak_pullup;
      logic id_pullup;
      logic regulator_2v8;
      logic regulator_bypass_on;
      logic bus_power_charge;
      logic bus_power_discharge;
      logic right_or_mic_switch;
      logic left_speaker_switch;
      logic right_line_bias;
      logic left_line_bias;
      logic rx_pulse_enable;
      logic dm_drive;
      logic dm_drive_en;
   } otgm_line_ctrl_t;

   // Session request sequence phases, one-hot.
   typedef enum logic [3:0] {
      OTGM_SRP_IDLE      = 4'h1,
      OTGM_SRP_PULLUP    = 4'h2,
      OTGM_SRP_CHARGE    = 4'h4,
      OTGM_SRP_DISCHARGE = 4'h8
   } otgm_srp_state_t;

endpackage : otgm_pkg

// ### hdl/otgm_regs.sv
`timescale 1ns/1ps
`include "otgm_defs.svh"

module otgm_regs #(
   parameter int unsigned SRP_PULLUP_CYCLES    =
      32'((`OTGM_SRP_PULLUP_US * `OTGM_CLK_KHZ + 64'd999) / 64'd1000),
   parameter int unsigned SRP_CHARGE_CYCLES    =
      32'((`OTGM_SRP_CHARGE_US * `OTGM_CLK_KHZ + 64'd999) / 64'd1000),
   parameter int unsigned SRP_DISCHARGE_CYCLES =
      32'((`OTGM_SRP_DISCHARGE_US * `OTGM_CLK_KHZ + 64'd999) / 64'd1000)
) (
   // Clock and reset.
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // Wishbone classic slave.
   input  wire logic                    wb_cyc_i,
   input  wire logic                    wb_stb_i,
   input  wire logic                    wb_we_i,
   input  wire logic [7:0]              wb_adr_i,
   input  wire logic [3:0]              wb_sel_i,
   input  wire logic [31:0]             wb_dat_i,
   output logic      [31:0]             wb_dat_o,
   output logic                         wb_ack_o,
   // Status from elsewhere in the transceiver, asynchronous.
   input  wire logic                    uart_pass_through_i,
   input  wire logic                    supply_below_3v6_i,
   // Line and analog controls.
   output otgm_pkg::otgm_line_ctrl_t    line_ctrl_o
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Applies a set-or-clear write of the low byte under a field mask.
   function automatic logic [7:0] set_clear(input logic [7:0] cur,
                                            input logic [7:0] wdata,
                                            input logic       is_set,
                                            input logic [7:0] mask);
      logic [7:0] res;
      res = is_set ? (cur | wdata) : (cur & ~wdata);
      return res & mask;
   endfunction : set_clear

   // A width of zero would wrap to a 256-tick phase, so it counts as one.
   function automatic logic [7:0] min_one(input logic [7:0] w);
      return (w == 8'h00) ? 8'h01 : w;
   endfunction : min_one

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [1:0] uart_sync_reg;
   logic [1:0] low_supply_sync_reg;
   logic       uart_en;
   logic       low_supply;

   // Both inputs come from analog or foreign logic and are resynchronised.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         uart_sync_reg       <= 2'h0;
         low_supply_sync_reg <= 2'h0;
      end else begin
         uart_sync_reg       <= {uart_sync_reg[0], uart_pass_through_i};
         low_supply_sync_reg <= {low_supply_sync_reg[0], supply_below_3v6_i};
      end
   end

   assign uart_en    = uart_sync_reg[1];
   assign low_supply = low_supply_sync_reg[1];

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   logic       req;
   logic       wr_take;
   logic [5:0] idx;
   logic       byte0_wr;
   logic [7:0] wbyte;
   logic [7:0] rdata;

   assign req      = wb_cyc_i & wb_stb_i;
   // Writes land on the edge where the master sees acknowledge high.
   assign wr_take  = req & wb_we_i & wb_ack_o;
   assign idx      = wb_adr_i[7:2];
   assign byte0_wr = wr_take & wb_sel_i[0];
   assign wbyte    = wb_dat_i[7:0];

   logic [7:0] misc_reg;
   logic [7:0] car_reg;
   logic [7:0] hi_width_reg;
   logic [7:0] lo_width_reg;

   // Read mux; unmapped words read as zero.
   always_comb begin
      case (idx)
         `OTGM_IDX_MISC_SET,
         `OTGM_IDX_MISC_CLR: rdata = misc_reg;
         `OTGM_IDX_CAR_SET,
         `OTGM_IDX_CAR_CLR:  rdata = car_reg;
         `OTGM_IDX_HI_WIDTH: rdata = hi_width_reg;
         `OTGM_IDX_LO_WIDTH: rdata = lo_width_reg;
         default:            rdata = 8'h00;
      endcase
   end

   // One wait state: acknowledge a cycle after the request, then drop.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         wb_dat_o <= {24'h00_0000, rdata};
      end
   end

   // ****************************************************************
   // Session request sequencer
   // ****************************************************************
   otgm_pkg::otgm_srp_state_t srp_state_reg;
   logic [31:0]               srp_cnt_reg;
   logic                      srp_done;
   logic                      srp_phase_end;

   assign srp_phase_end =
      ((srp_state_reg == otgm_pkg::OTGM_SRP_PULLUP) &&
       (srp_cnt_reg >= SRP_PULLUP_CYCLES - 1)) ||
      ((srp_state_reg == otgm_pkg::OTGM_SRP_CHARGE) &&
       (srp_cnt_reg >= SRP_CHARGE_CYCLES - 1)) ||
      ((srp_state_reg == otgm_pkg::OTGM_SRP_DISCHARGE) &&
       (srp_cnt_reg >= SRP_DISCHARGE_CYCLES - 1));
   assign srp_done = srp_phase_end &&
                     (srp_state_reg == otgm_pkg::OTGM_SRP_DISCHARGE);

   // The start bit launches the phases; each holds for its own count.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         srp_state_reg <= otgm_pkg::OTGM_SRP_IDLE;
         srp_cnt_reg   <= 32'h0000_0000;
      end else begin
         case (srp_state_reg)
            otgm_pkg::OTGM_SRP_IDLE: begin
               srp_cnt_reg <= 32'h0000_0000;
               if (misc_reg[`OTGM_MISC_SRP_START]) begin
                  srp_state_reg <= otgm_pkg::OTGM_SRP_PULLUP;
               end
            end
            otgm_pkg::OTGM_SRP_PULLUP: begin
               srp_cnt_reg <= srp_phase_end ? 32'h0000_0000 : srp_cnt_reg + 32'h1;
               if (srp_phase_end) begin
                  srp_state_reg <= otgm_pkg::OTGM_SRP_CHARGE;
               end
            end
            otgm_pkg::OTGM_SRP_CHARGE: begin
               srp_cnt_reg <= srp_phase_end ? 32'h0000_0000 : srp_cnt_reg + 32'h1;
               if (srp_phase_end) begin
                  srp_state_reg <= otgm_pkg::OTGM_SRP_DISCHARGE;
               end
            end
            otgm_pkg::OTGM_SRP_DISCHARGE: begin
               srp_cnt_reg <= srp_phase_end ? 32'h0000_0000 : srp_cnt_reg + 32'h1;
               if (srp_phase_end) begin
                  srp_state_reg <= otgm_pkg::OTGM_SRP_IDLE;
               end
            end
            default: begin
               srp_state_reg <= otgm_pkg::OTGM_SRP_IDLE;
               srp_cnt_reg   <= 32'h0000_0000;
            end
         endcase
      end
   end

   // ****************************************************************
   // Control registers
   // ****************************************************************
   logic [7:0] misc_next;

   // Set and clear addresses share storage. The start bit ignores the
   // clear address; a new set in the completion cycle wins and reruns.
   always_comb begin
      misc_next = misc_reg;
      if (srp_done) begin
         misc_next[`OTGM_MISC_SRP_START] = 1'b0;
      end
      if (byte0_wr && (idx == `OTGM_IDX_MISC_SET)) begin
         misc_next = set_clear(misc_next, wbyte, 1'b1,
                               `OTGM_MISC_MASK);
      end else if (byte0_wr && (idx == `OTGM_IDX_MISC_CLR)) begin
         misc_next = set_clear(misc_next, wbyte, 1'b0,
                               `OTGM_MISC_MASK);
         misc_next[`OTGM_MISC_SRP_START] =
            misc_reg[`OTGM_MISC_SRP_START] & ~srp_done;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         misc_reg <= `OTGM_MISC_RESET;
      end else begin
         misc_reg <= misc_next;
      end
   end

   // Accessory audio bits, same set and clear scheme.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         car_reg <= `OTGM_CAR_RESET;
      end else if (byte0_wr && (idx == `OTGM_IDX_CAR_SET)) begin
         car_reg <= set_clear(car_reg, wbyte, 1'b1, `OTGM_CAR_MASK);
      end else if (byte0_wr && (idx == `OTGM_IDX_CAR_CLR)) begin
         car_reg <= set_clear(car_reg, wbyte, 1'b0, `OTGM_CAR_MASK);
      end
   end

   // Pulse width registers, plain read and write.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hi_width_reg <= `OTGM_HI_WIDTH_RESET;
         lo_width_reg <= `OTGM_LO_WIDTH_RESET;
      end else if (byte0_wr) begin
         if (idx == `OTGM_IDX_HI_WIDTH) begin
            hi_width_reg <= wbyte;
         end
         if (idx == `OTGM_IDX_LO_WIDTH) begin
            lo_width_reg <= wbyte;
         end
      end
   end

   // ****************************************************************
   // Pulse period tick
   // ****************************************************************
   logic [7:0] phase_acc_reg;
   logic [7:0] phase_sum;
   logic       period_tick;

   // A fractional accumulator yields 60 ticks per 125 system cycles, so
   // each tick edge has up to one system cycle of jitter.
   assign phase_sum   = phase_acc_reg + `OTGM_PULSE_CLK_MHZ;
   assign period_tick = (phase_sum >= `OTGM_SYS_CLK_MHZ);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_acc_reg <= 8'h00;
      end else if (period_tick) begin
         phase_acc_reg <= phase_sum - `OTGM_SYS_CLK_MHZ;
      end else begin
         phase_acc_reg <= phase_sum;
      end
   end

   // ****************************************************************
   // Transmit pulse generator on the minus line
   // ****************************************************************
   logic       tx_enable;
   logic       pulse_high_reg;
   logic [7:0] pulse_cnt_reg;
   logic [7:0] pulse_width;
   logic       phase_end;

   assign tx_enable   = car_reg[`OTGM_CAR_TX_PULSE];
   assign pulse_width = pulse_high_reg ? min_one(hi_width_reg)
                                       : min_one(lo_width_reg);
   assign phase_end   = period_tick && (pulse_cnt_reg >= pulse_width - 8'h01);

   // Phases alternate; the width is read live on every tick, so a new width applies mid-phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_high_reg <= 1'b1;
         pulse_cnt_reg  <= 8'h00;
      end else if (!tx_enable) begin
         pulse_high_reg <= 1'b1;
         pulse_cnt_reg  <= 8'h00;
      end else if (phase_end) begin
         pulse_high_reg <= ~pulse_high_reg;
         pulse_cnt_reg  <= 8'h00;
      end else if (period_tick) begin
         pulse_cnt_reg  <= pulse_cnt_reg + 8'h01;
      end
   end

   // ****************************************************************
   // Registered line controls
   // ****************************************************************
   otgm_pkg::otgm_line_ctrl_t line_next;
   logic                      level_2v8;

   assign level_2v8 = uart_en & misc_reg[`OTGM_MISC_LEVEL_SEL];

   always_comb begin
      line_next = '0;
      // Force high wins if software sets both force bits.
      line_next.dp_drive_en = misc_reg[`OTGM_MISC_FORCE_HIGH] |
                              misc_reg[`OTGM_MISC_FORCE_LOW];
      line_next.dp_drive    = misc_reg[`OTGM_MISC_FORCE_HIGH];
      line_next.dp_pullup   = (srp_state_reg == otgm_pkg::OTGM_SRP_PULLUP);
      line_next.dp_weak_pullup = misc_reg[`OTGM_MISC_WEAK_PU];
      line_next.id_pullup   = ~misc_reg[`OTGM_MISC_ID_PU_DIS];
      line_next.regulator_2v8 = level_2v8;
      line_next.regulator_bypass_on = low_supply &
                                      ~misc_reg[`OTGM_MISC_BYPASS_DIS] &
                                      ~level_2v8;
      line_next.bus_power_charge =
         (srp_state_reg == otgm_pkg::OTGM_SRP_CHARGE);
      line_next.bus_power_discharge =
         (srp_state_reg == otgm_pkg::OTGM_SRP_DISCHARGE);
      line_next.right_or_mic_switch = car_reg[`OTGM_CAR_RIGHT_SW];
      line_next.left_speaker_switch = car_reg[`OTGM_CAR_LEFT_SW];
      line_next.right_line_bias = car_reg[`OTGM_CAR_RIGHT_BIAS];
      line_next.left_line_bias  = car_reg[`OTGM_CAR_LEFT_BIAS];
      line_next.rx_pulse_enable = car_reg[`OTGM_CAR_RX_PULSE];
      line_next.dm_drive_en = tx_enable;
      line_next.dm_drive    = tx_enable & pulse_high_reg;
   end

   // Every control leaves through a flip-flop to keep pins glitch free.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         line_ctrl_o <= '0;
      end else begin
         line_ctrl_o <= line_next;
      end
   end

endmodule : otgm_regs

// ### verif/otgm_accessory_model.sv
`timescale 1ns/1ps
// ************
// Accessory seen on the plus and minus lines
// ************
module otgm_accessory_model (
   // Clock and line controls.
   input  wire logic                      clk_i,
   input  wire otgm_pkg::otgm_line_ctrl_t ctrl_i,
   // Resolved plus line and measured phase lengths.
   output logic                           dp_level_o,
   output logic [4:0][15:0]               len_o
);
   logic [4:0]       act;
   logic [4:0][15:0] cnt;

   // A forced drive wins; else pull-ups lift it over the peer pull-down.
   assign dp_level_o = ctrl_i.dp_drive_en ? ctrl_i.dp_drive :
                       (ctrl_i.dp_pullup | ctrl_i.dp_weak_pullup);
   // Phases watched: minus high, minus low, pull-up, bus charge, bus discharge.
   assign act = {ctrl_i.dm_drive_en & ctrl_i.dm_drive, ctrl_i.dm_drive_en & ~ctrl_i.dm_drive,
                 ctrl_i.dp_pullup, ctrl_i.bus_power_charge, ctrl_i.bus_power_discharge};

   // Lengths of the last finished phases; pulse ones clear when pulses stop.
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 5; i++) begin
         cnt[i] <= act[i] ? cnt[i] + 16'h0001 : 16'h0000;
         if (!act[i] && cnt[i] != 16'h0000) begin
            len_o[i] <= cnt[i];
         end
      end
      if (!ctrl_i.dm_drive_en) begin
         len_o[4:3] <= '0;
      end
   end
endmodule : otgm_accessory_model

// ### verif/otgm_regs_assertions.sv
`timescale 1ns/1ps
`include "otgm_defs.svh"
// ************
// Port checker for the control register bank
// ************
module otgm_regs_assertions #(
   parameter int unsigned SRP_PULLUP_CYCLES    = 20,
   parameter int unsigned SRP_CHARGE_CYCLES    = 30,
   parameter int unsigned SRP_DISCHARGE_CYCLES = 15
) (
   // Clock and reset.
   input wire logic                      clk_i,
   input wire logic                      rst_i,
   // Register bus.
   input wire logic                      wb_cyc_i,
   input wire logic                      wb_stb_i,
   input wire logic                      wb_we_i,
   input wire logic [7:0]                wb_adr_i,
   input wire logic [3:0]                wb_sel_i,
   input wire logic [31:0]               wb_dat_i,
   input wire logic [31:0]               wb_dat_o,
   input wire logic                      wb_ack_o,
   // Status and line controls.
   input wire logic                      uart_pass_through_i,
   input wire logic                      supply_below_3v6_i,
   input wire otgm_pkg::otgm_line_ctrl_t line_ctrl_o
);
   localparam logic [7:0] MS = {`OTGM_IDX_MISC_SET, 2'b00};
   localparam logic [7:0] MC = {`OTGM_IDX_MISC_CLR, 2'b00};
   localparam logic [7:0] CS = {`OTGM_IDX_CAR_SET, 2'b00};
   logic             wr;
   logic [7:0]       wd;
   logic [2:0][31:0] run;

   // A write lands at the acknowledging edge.
   assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wd = wb_dat_i[7:0];

   // Cycles spent in each session-request phase.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run <= '0;
      end else begin
         run[2] <= line_ctrl_o.dp_pullup ? run[2] + 32'h1 : 32'h0;
         run[1] <= line_ctrl_o.bus_power_charge ? run[1] + 32'h1 : 32'h0;
         run[0] <= line_ctrl_o.bus_power_discharge ? run[0] + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack too long");
   property p_ack_answer; $rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
   property p_rd_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_force_high;
      wr && wb_adr_i == MS && wd[7] |-> ##2 line_ctrl_o.dp_drive_en && line_ctrl_o.dp_drive;
   endproperty
   a_force_high: assert property (p_force_high) else $error("plus line not high");
   property p_force_low; wr && wb_adr_i == MS && wd[6] |-> ##2 line_ctrl_o.dp_drive_en;
   endproperty
   a_force_low: assert property (p_force_low) else $error("plus line not driven");
   property p_id_pu; wr && wb_adr_i == MC && wd[3] |-> ##2 line_ctrl_o.id_pullup; endproperty
   a_id_pu: assert property (p_id_pu) else $error("id pull-up off");
   property p_bypass_off; !supply_below_3v6_i [*4] |-> !line_ctrl_o.regulator_bypass_on;
   endproperty
   a_bypass_off: assert property (p_bypass_off) else $error("bypass on");
   property p_tx_on; wr && wb_adr_i == CS && wd[0] |-> ##2 line_ctrl_o.dm_drive_en; endproperty
   a_tx_on: assert property (p_tx_on) else $error("minus drive off");
   property p_rx_on; wr && wb_adr_i == CS && wd[1] |-> ##2 line_ctrl_o.rx_pulse_enable;
   endproperty
   a_rx_on: assert property (p_rx_on) else $error("receive pulse off");
   property p_srp_start;
      wr && wb_adr_i == MS && wd[1] && !line_ctrl_o.dp_pullup && !line_ctrl_o.bus_power_charge
         && !line_ctrl_o.bus_power_discharge |-> ##[2:3] line_ctrl_o.dp_pullup;
   endproperty
   a_srp_start: assert property (p_srp_start) else $error("pull-up phase missing");
   property p_srp_next; $fell(line_ctrl_o.dp_pullup) |-> line_ctrl_o.bus_power_charge;
   endproperty
   a_srp_next: assert property (p_srp_next) else $error("charge phase missing");
   property p_pu_len; $fell(line_ctrl_o.dp_pullup) |-> run[2] == SRP_PULLUP_CYCLES; endproperty
   a_pu_len: assert property (p_pu_len) else $error("pull-up phase length");
   property p_chg_len; $fell(line_ctrl_o.bus_power_charge) |-> run[1] == SRP_CHARGE_CYCLES;
   endproperty
   a_chg_len: assert property (p_chg_len) else $error("charge phase length");
   property p_dis_len;
      $fell(line_ctrl_o.bus_power_discharge) |-> run[0] == SRP_DISCHARGE_CYCLES;
   endproperty
   a_dis_len: assert property (p_dis_len) else $error("discharge length");

   c_srp_done: cover property ($fell(line_ctrl_o.bus_power_discharge));
   c_dm_pulse: cover property ($rose(line_ctrl_o.dm_drive) && line_ctrl_o.dm_drive_en);
   c_forced_low: cover property (line_ctrl_o.dp_drive_en && !line_ctrl_o.dp_drive);
endmodule : otgm_regs_assertions

bind otgm_regs otgm_regs_assertions #(
   .SRP_PULLUP_CYCLES(SRP_PULLUP_CYCLES),
   .SRP_CHARGE_CYCLES(SRP_CHARGE_CYCLES),
   .SRP_DISCHARGE_CYCLES(SRP_DISCHARGE_CYCLES)
) u_chk (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
   .wb_dat_o, .wb_ack_o, .uart_pass_through_i, .supply_below_3v6_i, .line_ctrl_o
);

// ### verif/otgm_regs_tb.sv
`timescale 1ns/1ps
`include "otgm_defs.svh"
// ************
// Self-checking bench for the control register bank
// ************
module otgm_regs_tb;
   localparam logic [7:0] A_MS = {`OTGM_IDX_MISC_SET, 2'b00};
   localparam logic [7:0] A_CS = {`OTGM_IDX_CAR_SET, 2'b00};
   localparam logic [7:0] A_HW = {`OTGM_IDX_HI_WIDTH, 2'b00};
   localparam logic [7:0] A_LW = {`OTGM_IDX_LO_WIDTH, 2'b00};
   localparam int         PU = 20, CH = 30, DC = 15;
   logic                      clk_i = 1'b0, rst_i = 1'b1;
   logic                      wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]                wb_adr_i = 8'h00;
   logic [3:0]                wb_sel_i = 4'h0, sel_n = 4'hF;
   logic [31:0]               wb_dat_i = 32'h0, wb_dat_o;
   logic                      wb_ack_o, uart_i = 1'b0, sup_i = 1'b0, dp_level;
   otgm_pkg::otgm_line_ctrl_t line_ctrl_o;
   logic [4:0][15:0]          len;
   logic [7:0]                m, c, hw, lw, rd, a, d, hw_t [3], lw_t [3];
   int                        n, n_mismatch = 0, cmp_count = 0;

   // Free-running 125 MHz clock.
   always #4 clk_i = ~clk_i;

   otgm_regs #(.SRP_PULLUP_CYCLES(PU), .SRP_CHARGE_CYCLES(CH), .SRP_DISCHARGE_CYCLES(DC)) dut (
      .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .uart_pass_through_i(uart_i), .supply_below_3v6_i(sup_i),
      .line_ctrl_o);
   otgm_accessory_model peer (.clk_i, .ctrl_i(line_ctrl_o), .dp_level_o(dp_level), .len_o(len));

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic tmo(input string nm);
      n_mismatch++;
      $display("ERROR %s expected done seen timeout", nm);
      results();
   endtask : tmo

   // One classic cycle; the request stands until ack is sampled high.
   task automatic bus(input logic w, input logic [7:0] ad, wd, output logic [7:0] r);
      int t;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= ad;
      wb_sel_i <= sel_n;
      wb_dat_i <= {24'h0, wd};
      t = 0;
      do begin
         @(posedge clk_i);
         t++;
      end while (wb_ack_o !== 1'b1 && t < 64);
      if (t >= 64) tmo("bus_ack");
      r = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic do_reset;
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      m  = `OTGM_MISC_RESET;
      c  = `OTGM_CAR_RESET;
      hw = `OTGM_HI_WIDTH_RESET;
      lw = `OTGM_LO_WIDTH_RESET;
      @(posedge clk_i);
   endtask : do_reset

   // Reads all six words against the bench copy.
   task automatic chk_regs;
      logic [7:0] r, e [6];
      e = '{m, m, c, c, hw, lw};
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, A_MS + 8'(4 * i), 8'h00, r);
         chk("reg_read", {24'h0, e[i]}, {24'h0, r});
      end
   endtask : chk_regs

   function automatic otgm_pkg::otgm_line_ctrl_t exp_line(input logic u, input logic s);
      otgm_pkg::otgm_line_ctrl_t e;
      e = '0;
      e.dp_drive = m[7];
      e.dp_drive_en = m[7] | m[6];
      e.dp_weak_pullup = m[2];
      e.id_pullup = ~m[3];
      e.regulator_2v8 = m[4] & u;
      e.regulator_bypass_on = s & ~m[0] & ~(u & m[4]);
      e.right_or_mic_switch = c[5];
      e.left_speaker_switch = c[4];
      e.right_line_bias = c[3];
      e.left_line_bias = c[2];
      e.rx_pulse_enable = c[1];
      e.dm_drive_en = c[0];
      return e;
   endfunction : exp_line

   function automatic logic in_win(input logic [7:0] w, input logic [15:0] g);
      int e;
      e = ((w == 8'h00 ? 1 : int'(w)) * 125) / 60;
      return (int'(g) + 2 >= e) && (int'(g) <= e + 3);
   endfunction : in_win

   task automatic chk_line;
      otgm_pkg::otgm_line_ctrl_t g;
      g = line_ctrl_o;
      g.dm_drive = 1'b0;
      chk("line_ctrl", 32'(exp_line(uart_i, sup_i)), 32'(g));
      chk("dp_level", {31'h0, m[7] | (~m[6] & m[2])}, {31'h0, dp_level});
   endtask : chk_line

   // Main sequence.
   initial begin
      void'($urandom(64));
      do_reset;
      chk_regs;
      chk_line;
      sel_n = 4'hE;
      bus(1'b1, A_HW, 8'h77, rd);
      sel_n = 4'hF;
      bus(1'b1, 8'h40, 8'hFF, rd);
      bus(1'b0, 8'h40, 8'h00, rd);
      chk("unmapped", 32'h0, {24'h0, rd});
      chk_regs;
      $display("test reset_and_map done");
      for (int i = 0; i < 40; i++) begin
         uart_i <= 1'($urandom);
         sup_i  <= 1'($urandom);
         a = A_MS + 8'(4 * (i < 4 ? i : $urandom % 4));
         d = i < 4 ? 8'hFF : 8'($urandom);
         if (a == A_MS) d[1] = 1'b0;
         bus(1'b1, a, d, rd);
         case (a[3:2])
            2'h0: m = m | (d & `OTGM_MISC_MASK);
            2'h1: m = m & ~(d & `OTGM_MISC_MASK);
            2'h2: c = c | (d & `OTGM_CAR_MASK);
            default: c = c & ~(d & `OTGM_CAR_MASK);
         endcase
         chk_regs;
         chk_line;
      end
      $display("test set_clear done");
      hw_t = '{8'(1 + $urandom % 20), 8'hFF, 8'h00};
      lw_t = '{8'(1 + $urandom % 20), 8'h01, 8'h02};
      bus(1'b1, A_CS + 8'h04, 8'hFF, rd);
      c = 8'h00;
      for (int k = 0; k < 3; k++) begin
         hw = hw_t[k];
         lw = lw_t[k];
         bus(1'b1, A_HW, hw, rd);
         bus(1'b1, A_LW, lw, rd);
         chk_regs;
         bus(1'b1, A_CS, 8'h01, rd);
         for (n = 0; n < 1500 && len[3] == 16'h0; n++) @(posedge clk_i);
         if (n == 1500) tmo("dm_pulse");
         chk("hi_len", 32'h1, {31'h0, in_win(hw, len[4])});
         chk("lo_len", 32'h1, {31'h0, in_win(lw, len[3])});
         bus(1'b1, A_CS + 8'h04, 8'h01, rd);
      end
      $display("test pulses done");
      bus(1'b1, A_MS, 8'h02, rd);
      bus(1'b1, A_MS + 8'h04, 8'h02, rd);
      bus(1'b0, A_MS, 8'h00, rd);
      chk("srp_running", 32'h1, {31'h0, rd[1]});
      for (n = 0; n < 100; n++) begin
         bus(1'b0, A_MS, 8'h00, rd);
         if (rd[1] == 1'b0) break;
      end
      if (n == 100) tmo("srp_clear");
      chk("srp_cleared", {24'h0, m}, {24'h0, rd});
      chk("pullup_len", PU, {16'h0, len[2]});
      chk("charge_len", CH, {16'h0, len[1]});
      chk("discharge_len", DC, {16'h0, len[0]});
      $display("test session_request done");
      bus(1'b1, A_MS, 8'h02, rd);
      bus(1'b1, A_CS, 8'h01, rd);
      repeat (5) @(posedge clk_i);
      do_reset;
      chk_regs;
      repeat (3) @(posedge clk_i);
      chk_line;
      $display("test mid_run_reset done");
      results();
   end
endmodule : otgm_regs_tb
